// ==== ide_pkg.sv ====
// Constants shared by the disk task-file port: offsets, fields, commands, timing.
// Assumes a single 10 MHz system clock drives every user of this package.
`default_nettype none
package ide_pkg;
  // Register offsets on the host I/O bus
  localparam logic [35:0] DATA_OFS = 36'h00c8001f0;
  localparam logic [35:0] ERROR_OFS = 36'h00cc001f1;
  localparam logic [35:0] COUNT_OFS = 36'h00cc001f2;
  localparam logic [35:0] SECTOR_OFS = 36'h00cc001f3;
  localparam logic [35:0] CYL_LO_OFS = 36'h00cc001f4;
  localparam logic [35:0] CYL_HI_OFS = 36'h00cc001f5;
  localparam logic [35:0] DRVHD_OFS = 36'h00cc001f6;
  localparam logic [35:0] STATUS_OFS = 36'h00cc001f7;
  localparam logic [35:0] ALT_OFS = 36'h00cc003f6;
  localparam logic [35:0] LOOP_OFS = 36'h00cc003f7;
  localparam logic [35:0] CFG_OFS = 36'h00000000c;
  // Field positions
  localparam int CFG_AT_BIT = 6;
  localparam int DH_DRIVE_BIT = 4;
  localparam int CTL_RESET_BIT = 3;
  localparam int CTL_NOIRQ_BIT = 2;
  localparam int ER_UNC_BIT = 6;
  localparam int ER_IDNF_BIT = 4;
  localparam int ER_ABORT_BIT = 2;
  localparam int ER_TRK0_BIT = 1;
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h40;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h01;
  localparam logic [7:0] SECTOR_RESET = 8'h01;
  localparam logic [7:0] TF_RESET = 8'h00;
  // Command codes
  localparam logic [3:0] CMD_RECAL = 4'h1;
  localparam logic [3:0] CMD_SEEK = 4'h7;
  localparam logic [6:0] CMD_READ = 7'h10;
  localparam logic [6:0] CMD_READ_LONG = 7'h11;
  localparam logic [6:0] CMD_WRITE = 7'h18;
  localparam logic [6:0] CMD_WRITE_LONG = 7'h19;
  localparam logic [6:0] CMD_VERIFY = 7'h20;
  localparam logic [7:0] CMD_FORMAT = 8'h50;
  localparam logic [7:0] CMD_DIAG = 8'h90;
  localparam logic [7:0] CMD_INIT = 8'h91;
  localparam logic [7:0] CMD_BUF_RD = 8'he4;
  localparam logic [7:0] CMD_BUF_WR = 8'he8;
  localparam logic [7:0] CMD_IDENT = 8'hec;
  localparam logic [7:0] CMD_PWR_LO = 8'hf8;
  localparam logic [7:0] CMD_PWR_HI = 8'hfd;
  // Timing and sizes
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_PERIOD_NS = 3000;
  localparam int STEP_CYCLES = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WORDS_PER_SECTOR = 256;
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000,
    ENG_STEP = 3'b001,
    ENG_FETCH = 3'b010,
    ENG_XFER = 3'b011,
    ENG_ECC = 3'b100
  } eng_state_type;
endpackage
`default_nettype wire

// ==== pin_sync.sv ====
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the levels are quasi-static relative to the clock.
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,              // Sampling clock
  input wire logic arst_n,           // Async reset, active low
  input wire logic [WIDTH-1:0] d,    // Raw pin levels
  output logic [WIDTH-1:0] q         // Synchronised levels
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== ide_task_file.sv ====
// Task-file port of a disk interface: host registers, command engine, sector buffer.
// Assumes host strobes and the media byte stream are synchronous to REF_CLK.
`default_nettype none
// Overview of operation
// - AT mode when config bit 6 is one; otherwise task file ignored (XT).
// - Polled register transfers only; no DMA handshake exists.
// - Data port moves 16-bit words; long-read correction bytes move 8 bits.
// - Each data word is stored low byte first, then high byte.
// - Sector count zero means 256 sectors.
// - Drive/head register: bit 4 drive select, bits 3..0 head.
// - Status bits: busy, ready, fault, seek done, data request, corrected, index, error; corrected is always zero here.
// - Status refreshed at each command completion.
// - Reading primary status clears the pending interrupt.
// - Alternate status shows same value without clearing interrupt.
// - Writing the command register starts execution at once.
// - Control bit 3 holds both drives in reset.
// - Interrupts pass only while control bit 2 is zero.
// - Loopback location echoes drive and head select; bit 7 unused here.
// - Accept read, read long, write, write long, verify pairs; odd means no retry.
// - Accept recalibrate, format, seek, diagnostics, init, buffer, identify, power codes.
// - Recalibrate: busy, step to cylinder zero, then status, clear busy, interrupt.
// - Cylinder zero missed gives error and track-zero flag; not ready aborts.
// - Read sets busy, seeks if off-track, bad parameters give ID-not-found.
// - Every sector end sets data request and raises interrupt, error or not.
// - Host finishing a sector clears data request, sets busy if more sectors follow; error or last sector stops there.
// - Success leaves count zero, last address; addresses advance between sectors.
// - Long read returns one sector plus unchecked correction bytes only.
module ide_task_file
  import ide_pkg::*;
#(
  parameter logic [7:0] SECTORS_PER_TRACK = 8'd17,
  parameter logic [4:0] HEADS = 5'd16,
  parameter logic [15:0] CYLINDERS = 16'd1024,
  parameter logic [15:0] RECAL_MAX_STEPS = 16'd1024,
  parameter int ECC_BYTES = 4
) (
  input wire logic REF_CLK,            // 10 MHz clock
  input wire logic ARST_N,             // Async reset, active low
  input wire logic [35:0] IO_ADDR,     // Host I/O address
  input wire logic IO_RD,              // Host read strobe
  input wire logic IO_WR,              // Host write strobe
  input wire logic [15:0] IO_WDATA,    // Host write data
  output logic [15:0] IO_RDATA,        // Host read data, one cycle after strobe
  output logic IRQ,                    // Drive interrupt, active high
  output logic AT_MODE,                // AT interface mode selected
  output logic DRIVE_RST_N,            // Drive reset, active low
  output logic DRIVE_SEL,              // Selected drive
  output logic [3:0] HEAD_SEL,         // Selected head
  output logic STEP,                   // Head step pulse
  output logic STEP_DIR,               // Step direction, 1 toward cylinder zero
  input wire logic TRACK0,             // Heads at cylinder zero pin
  input wire logic INDEX,              // Index mark pin
  input wire logic FAULT,              // Drive fault pin
  input wire logic READY,              // Drive ready pin
  output logic MEDIA_REQ,              // Request one sector from the medium
  output logic [15:0] MEDIA_CYL,       // Requested cylinder
  output logic [7:0] MEDIA_SECTOR,     // Requested sector
  input wire logic MEDIA_VALID,        // Medium byte valid
  input wire logic [7:0] MEDIA_BYTE,   // Medium byte
  input wire logic MEDIA_ERR           // Uncorrectable flag with a byte
);
  localparam int WA = $clog2(WORDS_PER_SECTOR);
  localparam int EA = (ECC_BYTES > 1) ? $clog2(ECC_BYTES) : 1;
  localparam int TOTAL = 2 * WORDS_PER_SECTOR + ECC_BYTES;
  localparam int FW = $clog2(TOTAL + 1);
  localparam int TW = $clog2(STEP_CYCLES + 1);
  localparam logic [FW-1:0] LAST_BYTE = FW'(TOTAL - 1);
  localparam logic [FW-1:0] DATA_BYTES = FW'(2 * WORDS_PER_SECTOR);
  localparam logic [WA-1:0] LAST_WORD = WA'(WORDS_PER_SECTOR - 1);
  localparam logic [EA-1:0] LAST_ECC = EA'(ECC_BYTES - 1);
  localparam logic [TW-1:0] STEP_LOAD = TW'(STEP_CYCLES - 1);

  eng_state_type state;
  logic [7:0] cfg, ctl, err_reg, count, sector, cyl_lo, cyl_hi, drvhd;
  logic err_flag, dsc, pend, raise, long_cmd, recal, med_err;
  logic [15:0] cur_cyl, target, steps;
  logic [TW-1:0] tmr;
  logic [FW-1:0] fill_idx;
  logic [WA-1:0] rd_idx;
  logic [EA-1:0] ecc_idx;
  logic [15:0] buffer [WORDS_PER_SECTOR];
  logic [7:0] ecc_buf [ECC_BYTES];
  logic [3:0] pins;
  logic track0_s, index_s, fault_s, ready_s;

  pin_sync #(.WIDTH(4)) u_sync (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .d({TRACK0, INDEX, FAULT, READY}),
    .q(pins)
  );
  assign {track0_s, index_s, fault_s, ready_s} = pins;

  // Address decode
  wire at_mode = cfg[CFG_AT_BIT];
  wire soft_rst = ctl[CTL_RESET_BIT];
  wire acc = (IO_RD | IO_WR) & at_mode;
  wire hit_data = acc & (IO_ADDR == DATA_OFS);
  wire hit_err = acc & (IO_ADDR == ERROR_OFS);
  wire hit_count = acc & (IO_ADDR == COUNT_OFS);
  wire hit_sector = acc & (IO_ADDR == SECTOR_OFS);
  wire hit_cyl_lo = acc & (IO_ADDR == CYL_LO_OFS);
  wire hit_cyl_hi = acc & (IO_ADDR == CYL_HI_OFS);
  wire hit_drvhd = acc & (IO_ADDR == DRVHD_OFS);
  wire hit_status = acc & (IO_ADDR == STATUS_OFS);
  wire hit_alt = acc & (IO_ADDR == ALT_OFS);
  wire hit_loop = acc & (IO_ADDR == LOOP_OFS);
  wire hit_cfg = (IO_RD | IO_WR) & (IO_ADDR == CFG_OFS);

  // Status and engine conditions
  wire busy = soft_rst | (state == ENG_STEP) | (state == ENG_FETCH);
  wire data_request_flag = (state == ENG_XFER) | (state == ENG_ECC);
  wire idle = (state == ENG_IDLE) & !soft_rst;
  wire [7:0] status = {busy, ready_s, fault_s, dsc, data_request_flag, 1'b0, index_s, err_flag};
  wire [15:0] cyl = {cyl_hi, cyl_lo};
  wire [3:0] head = drvhd[3:0];
  wire tf_wr = IO_WR & idle;
  wire cmd_go = IO_WR & hit_status & idle;
  wire data_rd = IO_RD & hit_data;
  wire stat_rd = IO_RD & hit_status;

  // Command decode
  wire [7:0] cmd = IO_WDATA[7:0];
  wire is_recal = cmd[7:4] == CMD_RECAL;
  wire is_read = cmd[7:1] == CMD_READ;
  wire is_read_long = cmd[7:1] == CMD_READ_LONG;
  wire is_xfer_other = (cmd[7:1] == CMD_WRITE) | (cmd[7:1] == CMD_WRITE_LONG)
                     | (cmd[7:1] == CMD_VERIFY);
  wire is_misc = (cmd[7:4] == CMD_SEEK) | (cmd == CMD_FORMAT) | (cmd == CMD_DIAG)
               | (cmd == CMD_INIT) | (cmd == CMD_BUF_RD) | (cmd == CMD_BUF_WR)
               | (cmd == CMD_IDENT) | ((cmd >= CMD_PWR_LO) & (cmd <= CMD_PWR_HI));
  wire id_ok = (sector != 8'h00) & (sector <= SECTORS_PER_TRACK)
             & ({1'b0, head} < HEADS) & (cyl < CYLINDERS);

  // Sector progress
  wire fill_wr = (state == ENG_FETCH) & MEDIA_VALID;
  wire fill_last = fill_wr & (fill_idx == LAST_BYTE);
  wire fill_data = fill_idx < DATA_BYTES;
  wire [WA-1:0] fill_word = fill_idx[WA:1];
  wire [EA-1:0] fill_ecc = EA'(fill_idx - DATA_BYTES);
  wire sect_err = med_err & !long_cmd;
  wire word_end = data_rd & (state == ENG_XFER) & (rd_idx == LAST_WORD);
  wire ecc_end = data_rd & (state == ENG_ECC) & (ecc_idx == LAST_ECC);
  wire sect_end = (word_end & !long_cmd) | ecc_end;
  wire final_sect = err_flag | long_cmd | (count == 8'h01);
  wire at_target = recal ? track0_s : (cur_cyl == target);
  wire step_fail = recal & (steps == RECAL_MAX_STEPS);
  wire last_sect_on_trk = sector == SECTORS_PER_TRACK;
  wire last_head = {1'b0, head} == HEADS - 5'd1;

  // Read data selection
  wire [15:0] rd_word = (state == ENG_ECC) ? {8'h00, ecc_buf[ecc_idx]}
                      : (state == ENG_XFER) ? buffer[rd_idx] : 16'h0000;
  wire [15:0] next_rdata =
      hit_data ? rd_word
    : hit_err ? {8'h00, err_reg}
    : hit_count ? {8'h00, count}
    : hit_sector ? {8'h00, sector}
    : hit_cyl_lo ? {8'h00, cyl_lo}
    : hit_cyl_hi ? {8'h00, cyl_hi}
    : hit_drvhd ? {8'h00, drvhd}
    : (hit_status | hit_alt) ? {8'h00, status}
    : hit_loop ? {11'h000, drvhd[DH_DRIVE_BIT], head}
    : hit_cfg ? {8'h00, cfg}
    : 16'h0000;

  assign IRQ = pend & !ctl[CTL_NOIRQ_BIT] & !soft_rst;
  assign AT_MODE = at_mode;
  assign DRIVE_RST_N = !soft_rst;
  assign DRIVE_SEL = drvhd[DH_DRIVE_BIT];
  assign HEAD_SEL = head;
  assign MEDIA_CYL = cyl;
  assign MEDIA_SECTOR = sector;

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      IO_RDATA <= 16'h0000;
      cfg <= CFG_RESET;
      ctl <= CTL_RESET;
    end
    else
    begin
      if (IO_RD)
        IO_RDATA <= next_rdata;
      if (IO_WR & hit_cfg)
        cfg <= IO_WDATA[7:0];
      if (IO_WR & hit_alt)
        ctl <= IO_WDATA[7:0];
    end
  end

  // Pending interrupt, a new event wins over a status read
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      pend <= 1'b0;
    else if (soft_rst)
      pend <= 1'b0;
    else
      pend <= raise | (pend & !stat_rd);
  end

  // Sector buffer in flip-flops, low byte arrives first
  always_ff @(posedge REF_CLK)
  begin
    if (fill_wr & fill_data & !fill_idx[0])
      buffer[fill_word][7:0] <= MEDIA_BYTE;
    if (fill_wr & fill_data & fill_idx[0])
      buffer[fill_word][15:8] <= MEDIA_BYTE;
    if (fill_wr & !fill_data)
      ecc_buf[fill_ecc] <= MEDIA_BYTE;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state <= ENG_IDLE;
      err_reg <= 8'h00;
      err_flag <= 1'b0;
      dsc <= 1'b0;
      raise <= 1'b0;
      long_cmd <= 1'b0;
      recal <= 1'b0;
      med_err <= 1'b0;
      count <= COUNT_RESET;
      sector <= SECTOR_RESET;
      cyl_lo <= TF_RESET;
      cyl_hi <= TF_RESET;
      drvhd <= TF_RESET;
      cur_cyl <= 16'h0000;
      target <= 16'h0000;
      steps <= 16'h0000;
      tmr <= '0;
      fill_idx <= '0;
      rd_idx <= '0;
      ecc_idx <= '0;
      STEP <= 1'b0;
      STEP_DIR <= 1'b0;
      MEDIA_REQ <= 1'b0;
    end
    else if (soft_rst)
    begin
      state <= ENG_IDLE;
      err_reg <= 8'h00;
      err_flag <= 1'b0;
      raise <= 1'b0;
      STEP <= 1'b0;
      MEDIA_REQ <= 1'b0;
    end
    else
    begin
      raise <= 1'b0;
      STEP <= 1'b0;
      MEDIA_REQ <= 1'b0;
      if (tf_wr & hit_count)
        count <= IO_WDATA[7:0];
      if (tf_wr & hit_sector)
        sector <= IO_WDATA[7:0];
      if (tf_wr & hit_cyl_lo)
        cyl_lo <= IO_WDATA[7:0];
      if (tf_wr & hit_cyl_hi)
        cyl_hi <= IO_WDATA[7:0];
      if (tf_wr & hit_drvhd)
        drvhd <= IO_WDATA[7:0];
      unique case (state)
        ENG_IDLE:
        begin
          if (cmd_go)
          begin
            err_reg <= 8'h00;
            err_flag <= 1'b0;
            long_cmd <= is_read_long;
            recal <= is_recal;
            steps <= 16'h0000;
            tmr <= '0;
            if (!ready_s)
            begin
              err_reg[ER_ABORT_BIT] <= 1'b1;
              err_flag <= 1'b1;
              raise <= 1'b1;
            end
            else if (is_recal)
            begin
              dsc <= 1'b0;
              target <= 16'h0000;
              state <= ENG_STEP;
            end
            else if (is_read | is_read_long)
            begin
              if (!id_ok)
              begin
                err_reg[ER_IDNF_BIT] <= 1'b1;
                err_flag <= 1'b1;
                raise <= 1'b1;
              end
              else
              begin
                dsc <= 1'b0;
                target <= cyl;
                state <= ENG_STEP;
              end
            end
            else if (is_xfer_other | is_misc)
              raise <= 1'b1;
            else
            begin
              err_reg[ER_ABORT_BIT] <= 1'b1;
              err_flag <= 1'b1;
              raise <= 1'b1;
            end
          end
        end
        ENG_STEP:
        begin
          if (tmr != '0)
            tmr <= tmr - TW'(1);
          else if (at_target)
          begin
            cur_cyl <= target;
            dsc <= 1'b1;
            if (recal)
            begin
              raise <= 1'b1;
              state <= ENG_IDLE;
            end
            else
            begin
              fill_idx <= '0;
              med_err <= 1'b0;
              MEDIA_REQ <= 1'b1;
              state <= ENG_FETCH;
            end
          end
          else if (step_fail)
          begin
            err_reg[ER_TRK0_BIT] <= 1'b1;
            err_flag <= 1'b1;
            raise <= 1'b1;
            state <= ENG_IDLE;
          end
          else
          begin
            STEP <= 1'b1;
            STEP_DIR <= recal | (target < cur_cyl);
            steps <= steps + 16'h0001;
            tmr <= STEP_LOAD;
            if (!recal)
              cur_cyl <= (target < cur_cyl) ? cur_cyl - 16'h0001 : cur_cyl + 16'h0001;
          end
        end
        ENG_FETCH:
        begin
          if (fill_wr)
          begin
            fill_idx <= fill_idx + FW'(1);
            med_err <= med_err | MEDIA_ERR;
          end
          if (fill_last)
          begin
            rd_idx <= '0;
            ecc_idx <= '0;
            raise <= 1'b1;
            state <= ENG_XFER;
            if (sect_err | (MEDIA_ERR & !long_cmd))
            begin
              err_reg[ER_UNC_BIT] <= 1'b1;
              err_flag <= 1'b1;
            end
          end
        end
        ENG_XFER:
        begin
          if (data_rd)
            rd_idx <= rd_idx + WA'(1);
          if (word_end & long_cmd)
            state <= ENG_ECC;
        end
        ENG_ECC:
        begin
          if (data_rd)
            ecc_idx <= ecc_idx + EA'(1);
        end
        default:
          state <= ENG_IDLE;
      endcase
      if (sect_end)
      begin
        if (final_sect)
        begin
          state <= ENG_IDLE;
          if (!err_flag)
            count <= count - 8'h01;
        end
        else
        begin
          count <= count - 8'h01;
          fill_idx <= '0;
          med_err <= 1'b0;
          MEDIA_REQ <= 1'b1;
          state <= ENG_FETCH;
          if (last_sect_on_trk)
          begin
            sector <= 8'h01;
            if (last_head)
            begin
              drvhd[3:0] <= 4'h0;
              {cyl_hi, cyl_lo} <= cyl + 16'h0001;
            end
            else
              drvhd[3:0] <= head + 4'h1;
          end
          else
            sector <= sector + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== ide_tf_props.sv ====
// Checker for the disk task-file port, bound into ide_task_file.
// Sees only top-level ports; single clock, async active-low reset.
`default_nettype none
module ide_tf_props
  import ide_pkg::*;
(
  input wire logic REF_CLK, // Clock
  input wire logic ARST_N, // Reset
  input wire logic [35:0] IO_ADDR, // Address
  input wire logic IO_RD, // Read strobe
  input wire logic IO_WR, // Write strobe
  input wire logic [15:0] IO_WDATA, // Write data
  input wire logic [15:0] IO_RDATA, // Read data
  input wire logic IRQ, // Interrupt
  input wire logic AT_MODE, // Mode
  input wire logic DRIVE_RST_N, // Drive reset
  input wire logic DRIVE_SEL, // Drive
  input wire logic [3:0] HEAD_SEL, // Head
  input wire logic STEP, // Step pulse
  input wire logic MEDIA_REQ // Sector request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  wire ctl_wr = IO_WR && AT_MODE && IO_ADDR == ALT_OFS;
  mode_select_a: assert property (IO_WR && IO_ADDR == CFG_OFS
    |=> AT_MODE == $past(IO_WDATA[CFG_AT_BIT])) else $error("mode bit not applied");
  xt_reads_zero_a: assert property (!AT_MODE && IO_RD && IO_ADDR != CFG_OFS
    |=> IO_RDATA == 16'h0000) else $error("task file visible in xt mode");
  drive_reset_a: assert property (ctl_wr
    |=> DRIVE_RST_N == !$past(IO_WDATA[CTL_RESET_BIT])) else $error("drive reset wrong");
  irq_in_reset_a: assert property (!DRIVE_RST_N |-> !IRQ)
    else $error("interrupt during drive reset");
  irq_mask_a: assert property (ctl_wr && IO_WDATA[CTL_NOIRQ_BIT] |=> !IRQ)
    else $error("masked interrupt seen");
  select_echo_a: assert property (IO_RD && AT_MODE && IO_ADDR == LOOP_OFS
    |=> IO_RDATA[4:0] == {$past(DRIVE_SEL), $past(HEAD_SEL)}) else $error("loopback wrong");
  rdata_hold_a: assert property (!IO_RD |=> $stable(IO_RDATA))
    else $error("read data changed without read");
  step_gap_a: assert property (STEP |=> !STEP [*8])
    else $error("step pulses too close");
  req_pulse_a: assert property (MEDIA_REQ |=> !MEDIA_REQ)
    else $error("sector request not a pulse");
endmodule
bind ide_task_file ide_tf_props u_props (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
  .IO_ADDR(IO_ADDR), .IO_RD(IO_RD), .IO_WR(IO_WR), .IO_WDATA(IO_WDATA),
  .IO_RDATA(IO_RDATA), .IRQ(IRQ), .AT_MODE(AT_MODE), .DRIVE_RST_N(DRIVE_RST_N),
  .DRIVE_SEL(DRIVE_SEL), .HEAD_SEL(HEAD_SEL), .STEP(STEP), .MEDIA_REQ(MEDIA_REQ));
`default_nettype wire

// ==== disk_media_model.sv ====
// Drive-side model: head position and a 516-byte sector stream per request.
// Assumes MEDIA_REQ pulses come from the task-file engine on the same clock.
`default_nettype none
module disk_media_model (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic step, // Step pulse
  input wire logic step_dir, // 1 toward cylinder 0
  input wire logic media_req, // Sector request
  input wire logic slow, // Idle cycle between bytes
  input wire logic bad, // Mark bytes uncorrectable
  input wire logic load, // Load head position
  input wire logic [7:0] load_pos, // Position to load
  output logic track0, // Heads at cylinder 0
  output logic media_valid, // Byte strobe
  output logic [7:0] media_byte, // Byte
  output logic media_err // Uncorrectable mark
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pos;
  logic [9:0] cnt;
  logic run;
  logic gap;
  wire emit = run && (!slow || gap);
  assign track0 = pos == 8'h00;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      pos <= 8'h00;
    else if (load)
      pos <= load_pos;
    else if (step)
      pos <= step_dir ? pos - 8'h01 : pos + 8'h01;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      run <= 1'b0;
      gap <= 1'b0;
      cnt <= 10'h000;
      media_valid <= 1'b0;
      media_byte <= 8'h00;
      media_err <= 1'b0;
    end
    else
    begin
      gap <= run & slow & ~gap;
      if (media_req)
        run <= 1'b1;
      if (media_req)
        cnt <= 10'h000;
      else if (emit)
        cnt <= cnt + 10'h001;
      if (emit)
        run <= cnt != 10'h203;
      media_valid <= emit;
      media_byte <= emit ? cnt[7:0] : ~media_byte;
      media_err <= emit ? bad : ~media_err;
    end
endmodule
`default_nettype wire

// ==== ide_task_file_test.sv ====
// Self-checking bench for the disk task-file port with a drive-side model.
// Assumes one-cycle host strobes and a 10 MHz clock.
`default_nettype none
module test_ide_task_file_interface
  import ide_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, arst_n = 1'b0, rd_s = 1'b0, wr_s = 1'b0, rdy = 1'b1;
  logic slow = 1'b0, bad = 1'b0, load = 1'b0, flt = 1'b1, idx = 1'b1;
  logic [35:0] addr = 36'h0;
  logic [15:0] wdata = 16'h0, rdata, v;
  logic [7:0] load_pos = 8'h00, msec, mbyte;
  logic irq, at_mode, drst_n, dsel, step, sdir, trk0, mreq, mval, merr;
  logic [3:0] hsel;
  logic [15:0] mcyl;
  int err_count = 0, checks = 0, k;
  logic [35:0] ra [8] = '{COUNT_OFS, SECTOR_OFS, CYL_LO_OFS, CYL_HI_OFS, DRVHD_OFS,
    ERROR_OFS, CFG_OFS, 36'h00cc00100};
  logic [7:0] rv [8] = '{COUNT_RESET, SECTOR_RESET, TF_RESET, TF_RESET, TF_RESET,
    TF_RESET, CFG_RESET, 8'h00};
  logic [7:0] oc [20] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h40, 8'h41, 8'h50, 8'h70, 8'h7f,
    8'h90, 8'h91, 8'he4, 8'he8, 8'hec, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd};
  ide_task_file #(.RECAL_MAX_STEPS(16'h0008)) u_dut (.REF_CLK(clk), .ARST_N(arst_n),
    .IO_ADDR(addr), .IO_RD(rd_s), .IO_WR(wr_s), .IO_WDATA(wdata), .IO_RDATA(rdata),
    .IRQ(irq), .AT_MODE(at_mode), .DRIVE_RST_N(drst_n), .DRIVE_SEL(dsel),
    .HEAD_SEL(hsel), .STEP(step), .STEP_DIR(sdir), .TRACK0(trk0), .INDEX(idx),
    .FAULT(flt), .READY(rdy), .MEDIA_REQ(mreq), .MEDIA_CYL(mcyl),
    .MEDIA_SECTOR(msec), .MEDIA_VALID(mval), .MEDIA_BYTE(mbyte), .MEDIA_ERR(merr));
  disk_media_model u_media (.clk(clk), .arst_n(arst_n), .step(step), .step_dir(sdir),
    .media_req(mreq), .slow(slow), .bad(bad), .load(load), .load_pos(load_pos),
    .track0(trk0), .media_valid(mval), .media_byte(mbyte), .media_err(merr));
  initial
    forever #50 clk = ~clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [35:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [35:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rc(input string n, input logic [35:0] a, input logic [15:0] m,
    input logic [15:0] e);
    rd(a);
    chk(n, v & m, e);
  endtask
  task automatic wirq();
    for (int i = 0; i < 3000 && irq !== 1'b1; i++)
      @(negedge clk);
    chk("irq", irq, 1'b1);
  endtask
  task automatic rsec(input logic lng);
    for (int n = 0; n < WORDS_PER_SECTOR; n++)
    begin
      rd(DATA_OFS);
      chk("word", v, {n[6:0], 1'b1, n[6:0], 1'b0});
    end
    for (int n = 0; n < 4 && lng; n++)
    begin
      rd(DATA_OFS);
      chk("ecc", v[7:0], n[7:0]);
    end
  endtask
  task automatic place(input logic [7:0] p);
    @(posedge clk);
    load_pos <= p;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask
  initial
  begin
    #(60000 * 100);
    err_count++;
    close_out();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ra[i])
      rc("reset", ra[i], 16'h00ff, {8'h00, rv[i]});
    rc("pins", ALT_OFS, 16'h00ff, 16'h0062);
    wr(DRVHD_OFS, 16'h001a);
    chk("sel", {dsel, hsel}, 16'h001a);
    rc("loop", LOOP_OFS, 16'h007f, 16'h001a);
    wr(DRVHD_OFS, 16'h0000);
    foreach (oc[i])
    begin
      wr(STATUS_OFS, {8'h00, oc[i]});
      wirq();
      rc("done", STATUS_OFS, 16'h0081, 16'h0000);
    end
    wr(STATUS_OFS, 16'h0000);
    wirq();
    rc("alt", ALT_OFS, 16'h0081, 16'h0001);
    chk("keep", irq, 1'b1);
    rc("abort", ERROR_OFS, 16'h0004, 16'h0004);
    rc("stat", STATUS_OFS, 16'h0081, 16'h0001);
    chk("clear", irq, 1'b0);
    wr(ALT_OFS, 16'h0004);
    wr(STATUS_OFS, 16'h0090);
    repeat (4) @(negedge clk);
    chk("mask", irq, 1'b0);
    wr(ALT_OFS, 16'h0000);
    chk("unmask", irq, 1'b1);
    rd(STATUS_OFS);
    wr(ALT_OFS, 16'h0008);
    chk("rst", drst_n, 1'b0);
    rc("hold", ALT_OFS, 16'h0080, 16'h0080);
    wr(ALT_OFS, 16'h0000);
    place(8'h03);
    flt <= 1'b0;
    idx <= 1'b0;
    wr(STATUS_OFS, 16'h0010);
    rc("rbusy", ALT_OFS, 16'h0080, 16'h0080);
    wirq();
    rc("recal", STATUS_OFS, 16'h00ff, 16'h0050);
    chk("trk", trk0, 1'b1);
    slow <= 1'b1;
    wr(SECTOR_OFS, 16'h0011);
    wr(DRVHD_OFS, 16'h000f);
    wr(COUNT_OFS, 16'h0002);
    wr(STATUS_OFS, 16'h0020);
    rc("rdbsy", ALT_OFS, 16'h0088, 16'h0080);
    for (k = 1; k <= 2; k++)
    begin
      wirq();
      rc("drq", STATUS_OFS, 16'h0089, 16'h0008);
      chk("sec", msec, (k == 1) ? 16'h0011 : 16'h0001);
      rsec(1'b0);
      rc("next", ALT_OFS, 16'h0088, (k == 1) ? 16'h0080 : 16'h0000);
    end
    rc("cnt", COUNT_OFS, 16'h00ff, 16'h0000);
    rc("last", SECTOR_OFS, 16'h00ff, 16'h0001);
    chk("cyl", mcyl, 16'h0001);
    chk("head", hsel, 16'h0000);
    bad <= 1'b1;
    wr(SECTOR_OFS, 16'h0001);
    wr(COUNT_OFS, 16'h0002);
    wr(STATUS_OFS, 16'h0021);
    wirq();
    rc("edrq", STATUS_OFS, 16'h0089, 16'h0009);
    rsec(1'b0);
    rc("eend", ALT_OFS, 16'h0088, 16'h0000);
    rc("unc", ERROR_OFS, 16'h0040, 16'h0040);
    rc("esec", SECTOR_OFS, 16'h00ff, 16'h0001);
    chk("seek", trk0, 1'b0);
    wr(COUNT_OFS, 16'h0001);
    wr(STATUS_OFS, 16'h0022);
    wirq();
    rc("long", STATUS_OFS, 16'h0089, 16'h0008);
    rsec(1'b1);
    rc("lend", ALT_OFS, 16'h0088, 16'h0000);
    wr(SECTOR_OFS, 16'h0000);
    wr(STATUS_OFS, 16'h0020);
    wirq();
    rc("idnf", ERROR_OFS, 16'h0010, 16'h0010);
    rc("ierr", STATUS_OFS, 16'h0081, 16'h0001);
    @(posedge clk);
    rdy <= 1'b0;
    repeat (3) @(posedge clk);
    wr(STATUS_OFS, 16'h0010);
    wirq();
    rc("nrdy", ERROR_OFS, 16'h0004, 16'h0004);
    rd(STATUS_OFS);
    place(8'h14);
    rdy <= 1'b1;
    repeat (3) @(posedge clk);
    wr(STATUS_OFS, 16'h0010);
    wirq();
    rc("trk0", ERROR_OFS, 16'h0002, 16'h0002);
    rc("terr", STATUS_OFS, 16'h0081, 16'h0001);
    wr(CFG_OFS, 16'h0000);
    chk("mode", at_mode, 1'b0);
    rc("xt", COUNT_OFS, 16'hffff, 16'h0000);
    wr(CFG_OFS, 16'h0040);
    close_out();
  end
endmodule
`default_nettype wire
